/* rtl/two_wire_bus_master_controller.sv */
// Two-wire serial bus master with an APB register interface.
// Assumes SCL and SDA are open-drain with external pull-ups; the bench resolves
// the wires from the output enables. One 200 MHz clock, synchronous reset.
`timescale 1ns/1ps

// Overview of operation
// - With start request set, the next data write sends START then the byte.
// - Start request clears itself in the acknowledge slot after START.
// - Stop request during a byte makes STOP right after its acknowledge.
// - Stop request with the bus idle makes STOP at once.
// - Stop request clears when the STOP condition is complete.
// - Reads release SDA for eight bits, then drive acknowledge low.
// - Last-read set means SDA released at acknowledge, a not-acknowledge.
// - Last-read clears in the acknowledge slot.
// - Two read-only bits show the boot memory type detected at power-on.
// - Bus error flag set on unexpected low or lost arbitration.
// - Any data register access clears the bus error flag.
// - Write acknowledge: SDA released, sampled, stored inverted.
// - Acknowledge bit updates with done; ignored on reads.
// - Done and interrupt request set after each byte's acknowledge.
// - Data register access clears done and its interrupt request.
// - Eight-bit data register; an access with the engine idle and stop request low launches the next byte.
// - Stop interrupt enable raises a request on stop request falling.
// - Speed select picks about 100 kHz or about 400 kHz.
// - Speed starts slow, loads from boot setting, stays writable.
module two_wire_bus_master_controller (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        bootLoad,
  input  wire logic [1:0]  bootMemoryId,
  input  wire logic        bootFastSpeed,
  output logic             serialBusIrq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  two_wire_pkg::bus_state_t state_q, state_d;
  logic [1:0]  phase_q, phase_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  shift_q, shift_d;
  logic [7:0]  rxByte_q, rxByte_d;
  logic        sclOe_q, sclOe_d;
  logic        sdaOe_q, sdaOe_d;
  logic        ackSample_q, ackSample_d;
  logic        rxMode_q;
  logic [8:0]  divCnt_q;
  logic [2:0]  sclSync_q, sdaSync_q;
  logic        sclLevel_q, sdaLevel_q;
  logic        startReq_q, stopReq_q, stopPrev_q, lastRead_q;
  logic        busErr_q, ack_q, done_q, stopIrqPend_q;
  logic [1:0]  bootId_q;
  logic        fastSpeed_q, stopIrqEnable_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, serialBusIrq_q;
  logic        byteEnd, arbLost, stopDone;

  // --------------------------------------------------------------------------
  // Pin synchronisers: a level counts once stages two and three agree
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sclSync_q  <= 3'h7;
      sdaSync_q  <= 3'h7;
      sclLevel_q <= 1'b1;
      sdaLevel_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      if (sclSync_q[1] == sclSync_q[2]) sclLevel_q <= sclSync_q[2];
      if (sdaSync_q[1] == sdaSync_q[2]) sdaLevel_q <= sdaSync_q[2];
    end
  end

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready_q;
  wire hitCs      = paddr == two_wire_pkg::ADDR_CTRL_STATUS;
  wire hitData    = paddr == two_wire_pkg::ADDR_DATA;
  wire hitSpeed   = paddr == two_wire_pkg::ADDR_SPEED_CTRL;
  wire hitAny     = hitCs | hitData | hitSpeed;
  wire csWrite    = accessDone & pwrite & hitCs;
  wire csRead     = accessDone & ~pwrite & hitCs;
  wire dataAccess = accessDone & hitData;
  wire dataWrite  = dataAccess & pwrite;
  wire speedWrite = accessDone & pwrite & hitSpeed;

  wire [7:0] csValue = {startReq_q, stopReq_q, lastRead_q, bootId_q, busErr_q, ack_q, done_q};
  wire [7:0] speedValue = {6'h00, stopIrqEnable_q, fastSpeed_q};
  wire [7:0] readByte = hitCs    ? csValue :
                        hitData  ? rxByte_q :
                        hitSpeed ? speedValue : 8'h00;

  // Registered answer: data is captured in setup, so pready needs no wait state
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setupPhase;
      pslverr_q <= setupPhase & ~hitAny;
      if (setupPhase) prdata_q <= pwrite ? 32'h00000000 : {24'h000000, readByte};
    end
  end

  // --------------------------------------------------------------------------
  // Quarter-bit divider
  // --------------------------------------------------------------------------
  wire       stateIdle = state_q == two_wire_pkg::ST_IDLE;
  wire [8:0] reload    = fastSpeed_q ? two_wire_pkg::FAST_QUARTER_CYC - 9'h001
                                     : two_wire_pkg::STD_QUARTER_CYC - 9'h001;
  wire       tick      = ~stateIdle & (divCnt_q == 9'h000);
  // A slave stretching SCL holds the sample phase until the line really rises
  wire       advance   = tick & ~((phase_q == two_wire_pkg::PHASE_SAMPLE) & ~sclLevel_q);

  always_ff @(posedge clock) begin
    if (rst || stateIdle || tick) divCnt_q <= reload;
    else divCnt_q <= divCnt_q - 9'h001;
  end

  // --------------------------------------------------------------------------
  // Byte engine
  // --------------------------------------------------------------------------
  // Firmware waits for stop request low before touching the data register
  wire launch = dataAccess & stateIdle & ~stopReq_q;
  wire lastSlot = bitCnt_q == two_wire_pkg::ACK_SLOT;

  always_comb begin
    state_d     = state_q;
    phase_d     = phase_q;
    bitCnt_d    = bitCnt_q;
    shift_d     = shift_q;
    rxByte_d    = rxByte_q;
    sclOe_d     = sclOe_q;
    sdaOe_d     = sdaOe_q;
    ackSample_d = ackSample_q;
    byteEnd     = 1'b0;
    arbLost     = 1'b0;
    stopDone    = 1'b0;
    if (launch) begin
      // Start request must already be set when the byte is written
      state_d  = (pwrite & startReq_q) ? two_wire_pkg::ST_START : two_wire_pkg::ST_SHIFT;
      phase_d  = two_wire_pkg::PHASE_DRIVE;
      bitCnt_d = 4'h0;
      shift_d  = pwrite ? pwdata[7:0] : 8'h00;
    end else if (stateIdle & stopReq_q) begin
      state_d = two_wire_pkg::ST_STOP;
      phase_d = two_wire_pkg::PHASE_DRIVE;
    end else if (advance) begin
      phase_d = phase_q + 2'h1;
      unique case (state_q)
        two_wire_pkg::ST_START: begin
          unique case (phase_q)
            two_wire_pkg::PHASE_DRIVE:  sdaOe_d = 1'b0;
            two_wire_pkg::PHASE_RISE:   sclOe_d = 1'b0;
            two_wire_pkg::PHASE_SAMPLE: begin
              if (~sdaLevel_q) arbLost = 1'b1;
              else sdaOe_d = 1'b1;
            end
            two_wire_pkg::PHASE_FALL: begin
              sclOe_d = 1'b1;
              state_d = two_wire_pkg::ST_SHIFT;
            end
          endcase
        end
        two_wire_pkg::ST_SHIFT: begin
          unique case (phase_q)
            two_wire_pkg::PHASE_DRIVE: begin
              if (lastSlot) sdaOe_d = rxMode_q & ~lastRead_q;
              else sdaOe_d = ~rxMode_q & ~shift_q[7];
            end
            two_wire_pkg::PHASE_RISE: sclOe_d = 1'b0;
            two_wire_pkg::PHASE_SAMPLE: begin
              if (lastSlot) ackSample_d = sdaLevel_q;
              else if (rxMode_q) shift_d = {shift_q[6:0], sdaLevel_q};
              else if (~sdaOe_q & ~sdaLevel_q) arbLost = 1'b1;
              else shift_d = {shift_q[6:0], 1'b0};
            end
            two_wire_pkg::PHASE_FALL: begin
              sclOe_d = 1'b1;
              if (lastSlot) begin
                byteEnd = 1'b1;
                if (rxMode_q) rxByte_d = shift_q;
                state_d = stopReq_q ? two_wire_pkg::ST_STOP : two_wire_pkg::ST_IDLE;
              end else begin
                bitCnt_d = bitCnt_q + 4'h1;
              end
            end
          endcase
        end
        two_wire_pkg::ST_STOP: begin
          unique case (phase_q)
            two_wire_pkg::PHASE_DRIVE: begin
              sclOe_d = 1'b1;
              sdaOe_d = 1'b1;
            end
            two_wire_pkg::PHASE_RISE:   sclOe_d = 1'b0;
            two_wire_pkg::PHASE_SAMPLE: sdaOe_d = 1'b0;
            two_wire_pkg::PHASE_FALL: begin
              stopDone = 1'b1;
              state_d  = two_wire_pkg::ST_IDLE;
            end
          endcase
        end
        two_wire_pkg::ST_IDLE: ;
      endcase
      if (arbLost) begin
        // Losing the bus: let go of both lines and give the bus up
        state_d = two_wire_pkg::ST_IDLE;
        phase_d = two_wire_pkg::PHASE_DRIVE;
        sclOe_d = 1'b0;
        sdaOe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q     <= two_wire_pkg::ST_IDLE;
      phase_q     <= two_wire_pkg::PHASE_DRIVE;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      rxByte_q    <= 8'h00;
      sclOe_q     <= 1'b0;
      sdaOe_q     <= 1'b0;
      ackSample_q <= 1'b1;
      rxMode_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      phase_q     <= phase_d;
      bitCnt_q    <= bitCnt_d;
      shift_q     <= shift_d;
      rxByte_q    <= rxByte_d;
      sclOe_q     <= sclOe_d;
      sdaOe_q     <= sdaOe_d;
      ackSample_q <= ackSample_d;
      if (launch) rxMode_q <= ~pwrite;
    end
  end

  // --------------------------------------------------------------------------
  // Control and status flags; hardware set wins over a same-cycle clear
  // --------------------------------------------------------------------------
  wire stopFall    = stopPrev_q & ~stopReq_q;
  wire stopIrqSet  = stopFall & stopIrqEnable_q;
  wire doneNext    = byteEnd | (done_q & ~dataAccess);
  wire stopIrqNext = stopIrqSet | (stopIrqPend_q & ~csRead);

  always_ff @(posedge clock) begin
    if (rst) begin
      startReq_q    <= two_wire_pkg::START_RESET;
      stopReq_q     <= two_wire_pkg::STOP_RESET;
      stopPrev_q    <= two_wire_pkg::STOP_RESET;
      lastRead_q    <= two_wire_pkg::LAST_READ_RESET;
      busErr_q      <= two_wire_pkg::BUS_ERR_RESET;
      ack_q         <= two_wire_pkg::ACK_RESET;
      done_q        <= two_wire_pkg::DONE_RESET;
      stopIrqPend_q <= 1'b0;
    end else begin
      if (csWrite) startReq_q <= pwdata[two_wire_pkg::CS_START];
      else if (byteEnd) startReq_q <= 1'b0;
      if (csWrite) stopReq_q <= pwdata[two_wire_pkg::CS_STOP];
      else if (stopDone) stopReq_q <= 1'b0;
      if (csWrite) lastRead_q <= pwdata[two_wire_pkg::CS_LAST_READ];
      else if (byteEnd) lastRead_q <= 1'b0;
      stopPrev_q    <= stopReq_q;
      busErr_q      <= arbLost | (busErr_q & ~dataAccess);
      if (byteEnd) ack_q <= ~ackSample_q;
      done_q        <= doneNext;
      stopIrqPend_q <= stopIrqNext;
    end
  end

  // --------------------------------------------------------------------------
  // Speed control, boot identity and interrupt output
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      fastSpeed_q     <= two_wire_pkg::FAST_RESET;
      stopIrqEnable_q <= two_wire_pkg::STOP_IRQ_EN_RESET;
      bootId_q        <= two_wire_pkg::BOOT_ID_RESET;
      serialBusIrq_q  <= 1'b0;
    end else begin
      if (speedWrite) begin
        fastSpeed_q     <= pwdata[two_wire_pkg::SPD_FAST];
        stopIrqEnable_q <= pwdata[two_wire_pkg::SPD_STOP_IRQ_EN];
      end else if (bootLoad) begin
        fastSpeed_q <= bootFastSpeed;
      end
      if (bootLoad) bootId_q <= bootMemoryId;
      // One shared request; firmware tells done from stop by the status bits
      serialBusIrq_q <= doneNext | stopIrqNext;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign sclOe        = sclOe_q;
  assign sdaOe        = sdaOe_q;
  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign serialBusIrq = serialBusIrq_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_start_launch: assert property (dataWrite && stateIdle && !stopReq_q && startReq_q
    |=> state_q == two_wire_pkg::ST_START) else $error("start request did not launch START");
  chk_start_clear: assert property ($fell(startReq_q) |-> $past(byteEnd) || $past(csWrite))
    else $error("start request cleared outside acknowledge slot");
  chk_stop_after_ack: assert property (byteEnd && stopReq_q |=> state_q == two_wire_pkg::ST_STOP)
    else $error("stop not issued after acknowledge");
  chk_stop_idle: assert property (stateIdle && stopReq_q && !csWrite ##1 !csWrite
    |-> state_q == two_wire_pkg::ST_STOP) else $error("idle stop not issued at once");
  chk_stop_release: assert property (stopDone && !csWrite |=> !stopReq_q)
    else $error("stop request not cleared after STOP");
  chk_read_float: assert property (state_q == two_wire_pkg::ST_SHIFT && rxMode_q && !lastSlot
    && phase_q != two_wire_pkg::PHASE_DRIVE |-> !sdaOe_q) else $error("SDA driven while receiving");
  chk_last_nack: assert property (state_q == two_wire_pkg::ST_SHIFT && rxMode_q && lastSlot && lastRead_q
    && phase_q == two_wire_pkg::PHASE_SAMPLE |-> !sdaOe_q) else $error("last byte was acknowledged");
  chk_bus_error_flag_clear: assert property (dataAccess && !arbLost |=> !busErr_q)
    else $error("bus error not cleared by data access");
  chk_ack_invert: assert property (byteEnd && !rxMode_q |=> done_q && ack_q == !$past(ackSample_q))
    else $error("acknowledge bit not inverted sample");
  chk_done_irq: assert property (byteEnd |=> done_q && serialBusIrq_q ##1 (done_q || $past(dataAccess)))
    else $error("done or interrupt missing after byte");
  chk_done_clear: assert property (dataAccess && !byteEnd && !stopIrqNext |=> !done_q && !serialBusIrq_q)
    else $error("data access did not clear done");
  chk_stop_irq: assert property (stopFall && stopIrqEnable_q |=> serialBusIrq_q)
    else $error("stop interrupt missing");
  chk_divider_rate: assert property (tick |=> divCnt_q ==
    ($past(fastSpeed_q) ? two_wire_pkg::FAST_QUARTER_CYC : two_wire_pkg::STD_QUARTER_CYC) - 9'h001)
    else $error("divider reload wrong for speed");
  chk_last_clear: assert property (byteEnd && !csWrite |=> !lastRead_q)
    else $error("last-read flag not cleared at acknowledge");
  chk_boot_id: assert property (bootLoad |=> bootId_q == $past(bootMemoryId))
    else $error("boot memory id not loaded");
  chk_bus_error_flag_set: assert property (arbLost |=> busErr_q && !sdaOe_q && !sclOe_q)
    else $error("contention not flagged or lines not released");

endmodule : two_wire_bus_master_controller

/* rtl/two_wire_pkg.sv */
// Constants for the two-wire bus master controller: register map, field positions,
// reset values, bus timing and engine state encodings.
// Assumes a 200 MHz core clock and a 16-bit APB byte address.
package two_wire_pkg;

  // --------------------------------------------------------------------------
  // Clock and bus timing
  // --------------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ    = 200;
  localparam int STD_QUARTER_NS  = 2500; // quarter of a 10 us bit at about 100 kHz
  localparam int FAST_QUARTER_NS = 625;  // quarter of a 2.5 us bit at about 400 kHz
  localparam logic [8:0] STD_QUARTER_CYC  = 9'(STD_QUARTER_NS * CLK_FREQ_MHZ / 1000);
  localparam logic [8:0] FAST_QUARTER_CYC = 9'(FAST_QUARTER_NS * CLK_FREQ_MHZ / 1000);

  // --------------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_CTRL_STATUS = 16'hE678;
  localparam logic [15:0] ADDR_DATA        = 16'hE67C;
  localparam logic [15:0] ADDR_SPEED_CTRL  = 16'hE680;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int CS_START        = 7;
  localparam int CS_STOP         = 6;
  localparam int CS_LAST_READ    = 5;
  localparam int SPD_STOP_IRQ_EN = 1;
  localparam int SPD_FAST        = 0;
  localparam logic       START_RESET       = 1'b0;
  localparam logic       STOP_RESET        = 1'b0;
  localparam logic       LAST_READ_RESET   = 1'b0;
  localparam logic       BUS_ERR_RESET     = 1'b0;
  localparam logic       ACK_RESET         = 1'b0;
  localparam logic       DONE_RESET        = 1'b0;
  localparam logic       FAST_RESET        = 1'b0;
  localparam logic       STOP_IRQ_EN_RESET = 1'b0;
  localparam logic [1:0] BOOT_ID_RESET     = 2'h0;

  // --------------------------------------------------------------------------
  // Byte framing
  // --------------------------------------------------------------------------
  localparam logic [3:0] ACK_SLOT   = 4'h8; // bits 0..7 data, slot 8 acknowledge
  localparam logic [1:0] PHASE_DRIVE = 2'h0;
  localparam logic [1:0] PHASE_RISE  = 2'h1;
  localparam logic [1:0] PHASE_SAMPLE = 2'h2;
  localparam logic [1:0] PHASE_FALL  = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_STOP  = 4'b1000
  } bus_state_t;

endpackage : two_wire_pkg

/* tb/bus_slave_model.sv */
// Behavioural two-wire slave: acknowledges bytes while ackOn is high and answers
// reads with a fixed byte, most significant bit first.
// Assumes the bench resolves the open-drain wires with pull-ups.
`timescale 1ns/1ps
module bus_slave_model #(
  parameter logic [7:0] TX_BYTE = 8'hA5
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ackOn,
  output logic      sdaOe
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] rxByte = 8'h00;
  logic       active = 1'b0;
  logic       rdMode = 1'b0;
  logic       first = 1'b0;
  initial sdaOe = 1'b0;
  // Start condition restarts the byte framing
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    cnt = 4'h0;
    first = 1'b1;
    rdMode = 1'b0;
  end
  always @(posedge sda) if (scl) active = 1'b0;
  always @(posedge scl) if (active) begin
    if (cnt < 4'h8) rxByte = {rxByte[6:0], sda};
    else if (rdMode && !first && sda) active = 1'b0;
    cnt = cnt + 4'h1;
  end
  // Drive only while scl is low so no false start or stop is made
  always @(negedge scl) begin
    if (!active) sdaOe = 1'b0;
    else if (cnt == 4'h8) begin
      sdaOe = (first || !rdMode) && ackOn;
      if (first) rdMode = rxByte[0];
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      first = 1'b0;
      sdaOe = rdMode && !TX_BYTE[7];
    end else sdaOe = rdMode && !first && !TX_BYTE[4'h7 - cnt];
  end
endmodule : bus_slave_model

/* tb/tb_two_wire_bus_master_controller.sv */
// Self-checking bench for the two-wire bus master: register table, then write,
// read, stop and contention cases against a behavioural slave.
// Assumes open-drain wires with pull-ups, resolved here from the enables.
`timescale 1ns/1ps
module tb_two_wire_bus_master_controller;
  localparam logic [15:0] CS = two_wire_pkg::ADDR_CTRL_STATUS;
  localparam logic [15:0] DT = two_wire_pkg::ADDR_DATA;
  localparam logic [15:0] SP = two_wire_pkg::ADDR_SPEED_CTRL;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] paddr = 16'h0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, serialBusIrq, slvOe;
  logic        bootLoad = 1'b0;
  logic [1:0]  bootMemoryId = 2'h0;
  logic        bootFastSpeed = 1'b0;
  logic        ackOn = 1'b1;
  logic        jam = 1'b0;
  logic        sclPrev_q = 1'b1;
  logic [7:0]  d;
  logic        e;
  int          gap_q = 0;
  int          lastGap_q = 0;
  int          nErrors = 0;
  int          samplesChecked = 0;
  wire         scl = sclOe ? sclOut : 1'b1;
  wire         sda = sdaOe ? sdaOut : !(slvOe || jam);
  logic [32:0] rows [5] = '{{SP, 8'hFF, 8'h03, 1'b0}, {SP, 8'h00, 8'h00, 1'b0},
    {16'hE684, 8'h5A, 8'h00, 1'b1}, {CS, 8'h9F, 8'h80, 1'b0}, {CS, 8'h20, 8'h20, 1'b0}};

  two_wire_bus_master_controller i_two_wire_bus_master_controller (
    .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(scl),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .bootLoad(bootLoad), .bootMemoryId(bootMemoryId), .bootFastSpeed(bootFastSpeed),
    .serialBusIrq(serialBusIrq));
  bus_slave_model i_bus_slave_model (.scl(scl), .sda(sda), .ackOn(ackOn), .sdaOe(slvOe));

  always #2.5 clock = ~clock;
  // Cycles between scl rises, to check the bit rate
  always @(posedge clock) begin
    sclPrev_q <= scl;
    gap_q <= (scl && !sclPrev_q) ? 0 : gap_q + 1;
    if (scl && !sclPrev_q) lastGap_q <= gap_q;
  end

  task automatic testDone;
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : testDone

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, wd};
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk(8'h00, 8'hFF);
        testDone();
      end
      @(posedge clock);
    end
    d = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Slow but bounded: a fast byte is about 5000 cycles
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    apb(CS, 1'b0, 8'h00);
    while (d[b] !== v) begin
      n++;
      if (n > 9000) begin
        chk(8'h00, 8'hFF);
        testDone();
      end
      apb(CS, 1'b0, 8'h00);
    end
  endtask : poll

  // -------------------------------------------------------------------------
  // Stimulus
  // -------------------------------------------------------------------------
  initial begin
    int n;
    n = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    apb(CS, 1'b0, 8'h00);
    chk(d, 8'h00);
    apb(SP, 1'b0, 8'h00);
    chk(d, 8'h00);
    foreach (rows[i]) begin
      apb(rows[i][32:17], 1'b1, rows[i][16:9]);
      apb(rows[i][32:17], 1'b0, 8'h00);
      chk(d, rows[i][8:1]);
      chk({7'h00, e}, {7'h00, rows[i][0]});
    end
    apb(CS, 1'b1, 8'h00);
    bootMemoryId <= 2'h2;
    bootFastSpeed <= 1'b1;
    bootLoad <= 1'b1;
    @(posedge clock);
    bootLoad <= 1'b0;
    apb(CS, 1'b0, 8'h00);
    chk(d & 8'h18, 8'h10);
    apb(SP, 1'b0, 8'h00);
    chk(d, 8'h01);
    apb(SP, 1'b1, 8'h03);
    apb(CS, 1'b1, 8'h40);
    // The idle STOP begins one quarter bit after the request is seen
    repeat (int'(two_wire_pkg::FAST_QUARTER_CYC) + 5) @(posedge clock);
    chk({6'h00, sclOe, sdaOe}, 8'h03);
    while (serialBusIrq !== 1'b1 && n < 3000) begin
      n++;
      @(posedge clock);
    end
    chk({7'h00, serialBusIrq}, 8'h01);
    apb(CS, 1'b0, 8'h00);
    chk(d & 8'h41, 8'h00);
    @(posedge clock);
    chk({7'h00, serialBusIrq}, 8'h00);
    apb(CS, 1'b1, 8'h80);
    apb(DT, 1'b1, 8'hA0);
    poll(0, 1'b1);
    chk(d & 8'h87, 8'h03);
    chk({7'h00, serialBusIrq}, 8'h01);
    chk(i_bus_slave_model.rxByte, 8'hA0);
    chk({7'h00, lastGap_q >= 499 && lastGap_q <= 515}, 8'h01);
    apb(DT, 1'b1, 8'h3C);
    @(posedge clock);
    chk({7'h00, serialBusIrq}, 8'h00);
    poll(0, 1'b1);
    chk(i_bus_slave_model.rxByte, 8'h3C);
    ackOn <= 1'b0;
    apb(DT, 1'b1, 8'h55);
    apb(CS, 1'b1, 8'h40);
    poll(0, 1'b1);
    chk(d & 8'h43, 8'h41);
    poll(6, 1'b0);
    chk({7'h00, i_bus_slave_model.active}, 8'h00);
    ackOn <= 1'b1;
    apb(CS, 1'b1, 8'h80);
    apb(DT, 1'b1, 8'hA1);
    poll(0, 1'b1);
    apb(DT, 1'b0, 8'h00);
    poll(0, 1'b1);
    chk({7'h00, i_bus_slave_model.active}, 8'h01);
    apb(CS, 1'b1, 8'h20);
    apb(DT, 1'b0, 8'h00);
    chk(d, 8'hA5);
    poll(0, 1'b1);
    chk(d & 8'h20, 8'h00);
    chk({7'h00, i_bus_slave_model.active}, 8'h00);
    apb(CS, 1'b1, 8'h40);
    poll(6, 1'b0);
    apb(CS, 1'b1, 8'h80);
    apb(DT, 1'b1, 8'hFF);
    repeat (1000) @(posedge clock);
    jam <= 1'b1;
    poll(2, 1'b1);
    chk(d & 8'h01, 8'h00);
    jam <= 1'b0;
    apb(DT, 1'b1, 8'h00);
    apb(CS, 1'b0, 8'h00);
    chk(d & 8'h04, 8'h00);
    // Reset in the middle of a byte must let go of both lines at once
    repeat (700) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({5'h00, sclOe, sdaOe, serialBusIrq}, 8'h00);
    apb(CS, 1'b0, 8'h00);
    chk(d, 8'h00);
    apb(SP, 1'b0, 8'h00);
    chk(d, 8'h00);
    testDone();
  end
endmodule : tb_two_wire_bus_master_controller
